/* inc/bcbm_consts.vh */
// Constants for the ones-count, carry, indirect and block word datapath
`ifndef BCBM_CONSTS_VH
`define BCBM_CONSTS_VH

// ----------------------------------------------------------------
// Absolute word address map
// ----------------------------------------------------------------
`define BCBM_IO_BASE 10'h000
`define BCBM_RELAY_BASE 10'h0C0
`define BCBM_DATA_BASE 10'h200

// ----------------------------------------------------------------
// Area select codes for the maintenance port
// ----------------------------------------------------------------
`define BCBM_AREA_IO 2'h0
`define BCBM_AREA_RELAY 2'h1
`define BCBM_AREA_DATA 2'h2
`define BCBM_AREA_ABS 2'h3

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define BCBM_OP_ONES 3'h0
`define BCBM_OP_CSET 3'h1
`define BCBM_OP_CCLR 3'h2
`define BCBM_OP_CTGL 3'h3
`define BCBM_OP_LOAD 3'h4
`define BCBM_OP_STORE 3'h5
`define BCBM_OP_COPY 3'h6
`define BCBM_OP_FILL 3'h7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BCBM_CARRY_RST 1'h0
`define BCBM_WORD_RST 16'h0000

`endif

/* src/bcbm_datapath.v */
// Word datapath: ones count, carry control, indirect and block moves
`timescale 1ns/10ps
`include "bcbm_consts.vh"

module bcbm_datapath #(
   parameter DW = 16,
   parameter AW = 10,
   parameter CW = 10
) (
   // Clock and reset
   input wire ref_clk,
   input wire nrst,
   // Scan request
   input wire scan_tick,
   input wire exec_cond,
   input wire [2:0] op_code,
   input wire [AW-1:0] src_addr,
   input wire [AW-1:0] dst_addr,
   input wire [CW-1:0] word_count,
   input wire [DW-1:0] fill_value,
   // Carry interface to neighbouring carry-using ops
   input wire carry_upd_en,
   input wire carry_upd_val,
   // Maintenance word port
   input wire mnt_wr_en,
   input wire mnt_rd_en,
   input wire [1:0] mnt_area,
   input wire [AW-1:0] mnt_offset,
   input wire [DW-1:0] mnt_wr_data,
   // Status and results
   output reg [DW-1:0] mnt_rd_data_ff,
   output reg carry_ff,
   output reg busy_ff,
   output reg done_ff
);

   // -------------------------------------------------------------
   // Storage and state
   // -------------------------------------------------------------
   localparam ST_IDLE = 1'b0; // Waiting for a scan request
   localparam ST_BLK = 1'b1; // Block copy or fill in progress

   reg [DW-1:0] mem [0:(1<<AW)-1]; // Absolute word space
   reg state_ff; // Controller state
   reg [AW-1:0] rd_ptr_ff; // Block source pointer
   reg [AW-1:0] wr_ptr_ff; // Block destination pointer
   reg [CW-1:0] left_ff; // Words still to move
   reg down_ff; // Copy walks from the top end
   reg fill_ff; // Block op is a fill
   reg [DW-1:0] fval_ff; // Latched fill constant

   // -------------------------------------------------------------
   // Helper functions
   // -------------------------------------------------------------
   // Number of set bits in a word
   function [DW-1:0] ones_of;
      input [DW-1:0] w;
      integer i;
      begin
         ones_of = `BCBM_WORD_RST;
         for (i = 0; i < DW; i = i + 1) begin
            ones_of = ones_of + {{(DW-1){1'b0}}, w[i]};
         end
      end
   endfunction

   // Area base plus offset gives the absolute address
   function [AW-1:0] abs_of;
      input [1:0] area;
      input [AW-1:0] off;
      begin
         case (area)
            `BCBM_AREA_IO: abs_of = `BCBM_IO_BASE + off;
            `BCBM_AREA_RELAY: abs_of = `BCBM_RELAY_BASE + off;
            `BCBM_AREA_DATA: abs_of = `BCBM_DATA_BASE + off;
            default: abs_of = off;
         endcase
      end
   endfunction

   // -------------------------------------------------------------
   // Combinational decode
   // -------------------------------------------------------------
   wire start = (state_ff == ST_IDLE) && scan_tick && exec_cond;
   wire [DW-1:0] src_word = mem[src_addr];
   wire [DW-1:0] dst_word = mem[dst_addr];
   wire [AW-1:0] ld_ptr = src_word[AW-1:0];
   wire [AW-1:0] st_ptr = dst_word[AW-1:0];
   wire [AW-1:0] mnt_abs = abs_of(mnt_area, mnt_offset);
   wire [CW-1:0] cnt_m1 = word_count - {{(CW-1){1'b0}}, 1'b1};
   wire [AW-1:0] cnt_off = cnt_m1[AW-1:0];
   wire go_down = dst_addr > src_addr;
   wire [AW-1:0] step = {{(AW-1){1'b0}}, 1'b1};
   wire last = left_ff == {{(CW-1){1'b0}}, 1'b1};

   // -------------------------------------------------------------
   // Word memory writes
   // -------------------------------------------------------------
   // Single-word ops write on the start cycle, blocks one per cycle
   always @(posedge ref_clk) begin
      if (state_ff == ST_BLK) begin
         if (fill_ff) begin
            mem[wr_ptr_ff] <= fval_ff;
         end else begin
            mem[wr_ptr_ff] <= mem[rd_ptr_ff];
         end
      end else if (start) begin
         case (op_code)
            `BCBM_OP_ONES: mem[dst_addr] <= ones_of(src_word);
            `BCBM_OP_LOAD: mem[dst_addr] <= mem[ld_ptr];
            `BCBM_OP_STORE: mem[st_ptr] <= src_word;
            default: ;
         endcase
      end else if (mnt_wr_en) begin
         mem[mnt_abs] <= mnt_wr_data;
      end
   end

   // -------------------------------------------------------------
   // Carry flag
   // -------------------------------------------------------------
   // Own ops take priority over neighbour updates in the same cycle
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         carry_ff <= `BCBM_CARRY_RST;
      end else if (start && op_code == `BCBM_OP_CSET) begin
         carry_ff <= 1'b1;
      end else if (start && op_code == `BCBM_OP_CCLR) begin
         carry_ff <= 1'b0;
      end else if (start && op_code == `BCBM_OP_CTGL) begin
         carry_ff <= ~carry_ff;
      end else if (carry_upd_en) begin
         carry_ff <= carry_upd_val;
      end
   end

   // -------------------------------------------------------------
   // Controller
   // -------------------------------------------------------------
   // Launches ops and walks block pointers
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= ST_IDLE;
         rd_ptr_ff <= {AW{1'b0}};
         wr_ptr_ff <= {AW{1'b0}};
         left_ff <= {CW{1'b0}};
         down_ff <= 1'b0;
         fill_ff <= 1'b0;
         fval_ff <= `BCBM_WORD_RST;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         case (state_ff)
            ST_IDLE: begin
               if (start) begin
                  if ((op_code == `BCBM_OP_COPY ||
                       op_code == `BCBM_OP_FILL) &&
                      word_count != {CW{1'b0}}) begin
                     // Copy toward higher addresses walks downward
                     if (op_code == `BCBM_OP_COPY && go_down) begin
                        rd_ptr_ff <= src_addr + cnt_off;
                        wr_ptr_ff <= dst_addr + cnt_off;
                     end else begin
                        rd_ptr_ff <= src_addr;
                        wr_ptr_ff <= dst_addr;
                     end
                     down_ff <= (op_code == `BCBM_OP_COPY) && go_down;
                     fill_ff <= op_code == `BCBM_OP_FILL;
                     fval_ff <= fill_value;
                     left_ff <= word_count;
                     state_ff <= ST_BLK;
                     busy_ff <= 1'b1;
                  end else begin
                     // Single-cycle op or empty block
                     done_ff <= 1'b1;
                  end
               end
            end
            ST_BLK: begin
               // Consecutive addresses: step pointers by one word
               if (down_ff) begin
                  rd_ptr_ff <= rd_ptr_ff - step;
                  wr_ptr_ff <= wr_ptr_ff - step;
               end else begin
                  rd_ptr_ff <= rd_ptr_ff + step;
                  wr_ptr_ff <= wr_ptr_ff + step;
               end
               left_ff <= left_ff - {{(CW-1){1'b0}}, 1'b1};
               if (last) begin
                  state_ff <= ST_IDLE;
                  busy_ff <= 1'b0;
                  done_ff <= 1'b1;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
               busy_ff <= 1'b0;
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // Maintenance read
   // -------------------------------------------------------------
   // Registered read of any word by area and offset
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         mnt_rd_data_ff <= `BCBM_WORD_RST;
      end else if (mnt_rd_en) begin
         mnt_rd_data_ff <= mem[mnt_abs];
      end
   end

endmodule

/* test/bcbm_monitor.sv */
// Checker of carry, start and completion timing
`timescale 1ns/10ps
`include "bcbm_consts.vh"
module bcbm_monitor #(
   parameter CW = 10
) (
   // Clock and reset
   input logic ref_clk,
   input logic nrst,
   // Requests
   input logic scan_tick,
   input logic exec_cond,
   input logic [2:0] op_code,
   input logic [CW-1:0] word_count,
   input logic carry_upd_en,
   input logic carry_upd_val,
   // Results
   input logic carry_ff,
   input logic busy_ff,
   input logic done_ff
);
   logic go; // Request taken at this edge
   logic cop; // Taken request owns the carry
   assign go = scan_tick && exec_cond && !busy_ff;
   assign cop = go && op_code inside {3'h1, 3'h2, 3'h3};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // Taken request of one operation code
   sequence s_op(c);
      go && op_code == c;
   endsequence
   // Taken block request with words to move
   sequence s_blk;
      go && op_code >= `BCBM_OP_COPY && word_count != 0;
   endsequence
   chk_carry_set:
      assert property (s_op(`BCBM_OP_CSET) |=> carry_ff) else $error("set");
   chk_carry_clear:
      assert property (s_op(`BCBM_OP_CCLR) |=> !carry_ff) else $error("clr");
   chk_carry_toggle:
      assert property (s_op(`BCBM_OP_CTGL) |=> carry_ff != $past(carry_ff))
      else $error("toggle");
   chk_carry_upd:
      assert property (carry_upd_en && !cop |=> carry_ff == $past(carry_upd_val))
      else $error("carry update");
   chk_carry_hold:
      assert property (!carry_upd_en && !cop |=> $stable(carry_ff))
      else $error("carry moved");
   chk_single_done:
      assert property (go && op_code < `BCBM_OP_COPY |=> done_ff && !busy_ff)
      else $error("single done");
   chk_block_busy:
      assert property (s_blk |=> busy_ff && !done_ff) else $error("busy");
   chk_block_end:
      assert property ($fell(busy_ff) |-> done_ff) else $error("block end");
   chk_stray_done:
      assert property (!go && !busy_ff |=> !done_ff) else $error("stray done");
endmodule
bind bcbm_datapath bcbm_monitor #(.CW(CW)) bcbm_monitor_inst (.ref_clk, .nrst,
   .scan_tick, .exec_cond, .op_code, .word_count, .carry_upd_en,
   .carry_upd_val, .carry_ff, .busy_ff, .done_ff);

/* test/tb_bcbm_datapath.sv */
// Self-checking bench of the word datapath
`timescale 1ns/10ps
`include "bcbm_consts.vh"
module tb_bcbm_datapath;
   // ----------------
   // Design ports
   // ----------------
   logic ref_clk = 0, nrst = 0, scan_tick = 0, exec_cond = 0;
   logic carry_upd_en = 0, carry_upd_val = 0, mnt_wr_en = 0, mnt_rd_en = 0;
   logic [2:0] op_code = 0;
   logic [1:0] mnt_area = 0;
   logic [9:0] src_addr = 0, dst_addr = 0, word_count = 0, mnt_offset = 0;
   logic [15:0] fill_value = 0, mnt_wr_data = 0, mnt_rd_data_ff;
   logic carry_ff, busy_ff, done_ff;
   int fail_count = 0, n_tests = 0;
   always #5 ref_clk = ~ref_clk; // 100 MHz
   bcbm_datapath bcbm_datapath_inst (.ref_clk, .nrst, .scan_tick, .exec_cond,
      .op_code, .src_addr, .dst_addr, .word_count, .fill_value, .carry_upd_en,
      .carry_upd_val, .mnt_wr_en, .mnt_rd_en, .mnt_area, .mnt_offset,
      .mnt_wr_data, .mnt_rd_data_ff, .carry_ff, .busy_ff, .done_ff);
   // Compare and count
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Maintenance write, or read and compare
   task automatic mem(input logic w, input logic [1:0] a,
         input logic [9:0] o, input logic [15:0] d);
      @(posedge ref_clk);
      mnt_wr_en <= w;
      mnt_rd_en <= !w;
      mnt_area <= a;
      mnt_offset <= o;
      mnt_wr_data <= d;
      @(posedge ref_clk);
      mnt_wr_en <= 0;
      mnt_rd_en <= 0;
      #1 if (!w) chk(mnt_rd_data_ff, d);
   endtask
   // One scan request; done must come only when the condition holds
   task automatic run(input logic [2:0] c, input logic [9:0] s, d, n,
         input logic [15:0] f, input logic e);
      int i;
      @(posedge ref_clk);
      scan_tick <= 1;
      exec_cond <= e;
      op_code <= c;
      src_addr <= s;
      dst_addr <= d;
      word_count <= n;
      fill_value <= f;
      @(posedge ref_clk);
      scan_tick <= 0;
      #1;
      for (i = 0; i < 40 && done_ff !== 1'b1; i++) @(posedge ref_clk) #1;
      chk(i < 40, e);
   endtask
   task automatic t_ones();
      mem(1'b1, 2'h2, 10'h000, 16'hE7B3);
      run(`BCBM_OP_ONES, 10'h200, 10'h201, 10'h000, 16'h0000, 1'b1);
      mem(1'b0, 2'h2, 10'h001, 16'h000B);
      mem(1'b1, 2'h2, 10'h000, 16'hFFFF);
      run(`BCBM_OP_ONES, 10'h200, 10'h201, 10'h000, 16'h0000, 1'b1);
      mem(1'b0, 2'h2, 10'h001, 16'h0010);
   endtask
   task automatic t_carry();
      logic [2:0] c [6] = '{3'h1, 3'h3, 3'h3, 3'h2, 3'h2, 3'h1};
      logic x [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
      for (int i = 0; i < 6; i++) begin
         run(c[i], 10'h000, 10'h000, 10'h000, 16'h0000, i < 5);
         chk(carry_ff, x[i]);
      end
      @(posedge ref_clk);
      carry_upd_en <= 1;
      carry_upd_val <= 1;
      @(posedge ref_clk);
      carry_upd_en <= 0;
      #1 chk(carry_ff, 1'b1);
      // Own carry op wins over a neighbour update in one cycle
      @(posedge ref_clk);
      scan_tick <= 1;
      exec_cond <= 1;
      op_code <= `BCBM_OP_CCLR;
      carry_upd_en <= 1;
      @(posedge ref_clk);
      scan_tick <= 0;
      carry_upd_en <= 0;
      #1 chk(carry_ff, 1'b0);
   endtask
   task automatic t_indirect();
      mem(1'b1, 2'h1, 10'h000, 16'h0264);
      mem(1'b1, 2'h2, 10'h064, 16'h0022);
      run(`BCBM_OP_LOAD, 10'h0C0, 10'h002, 10'h000, 16'h0000, 1'b1);
      mem(1'b0, 2'h0, 10'h002, 16'h0022);
      mem(1'b1, 2'h0, 10'h001, 16'h0034);
      mem(1'b1, 2'h1, 10'h000, 16'h0265);
      run(`BCBM_OP_STORE, 10'h001, 10'h0C0, 10'h000, 16'h0000, 1'b1);
      mem(1'b0, 2'h3, 10'h265, 16'h0034);
      mem(1'b0, 2'h2, 10'h065, 16'h0034);
   endtask
   task automatic t_block();
      logic [15:0] v [3] = '{16'h12AA, 16'h340F, 16'h56F0};
      for (int i = 0; i < 3; i++) mem(1'b1, 2'h2, 10'h010 + i[9:0], v[i]);
      mem(1'b1, 2'h1, 10'h005, 16'h1234);
      run(`BCBM_OP_COPY, 10'h210, 10'h211, 10'h003, 16'h0000, 1'b1);
      for (int i = 0; i < 3; i++)
         mem(1'b0, 2'h2, 10'h011 + i[9:0], v[i]);
      run(`BCBM_OP_FILL, 10'h000, 10'h0C1, 10'h004, 16'h55AA, 1'b1);
      run(`BCBM_OP_FILL, 10'h000, 10'h0C1, 10'h000, 16'h0000, 1'b1);
      for (int i = 1; i < 5; i++)
         mem(1'b0, 2'h1, i[9:0], 16'h55AA);
      mem(1'b0, 2'h1, 10'h005, 16'h1234);
   endtask
   // Start and maintenance write while a fill runs are both dropped
   task automatic t_refuse();
      int i;
      mem(1'b1, 2'h1, 10'h009, 16'h0000);
      @(posedge ref_clk);
      scan_tick <= 1;
      exec_cond <= 1;
      op_code <= `BCBM_OP_FILL;
      dst_addr <= 10'h0C6;
      word_count <= 10'h003;
      fill_value <= 16'h0F0F;
      @(posedge ref_clk);
      op_code <= `BCBM_OP_CSET;
      mnt_wr_en <= 1;
      mnt_area <= 2'h1;
      mnt_offset <= 10'h009;
      mnt_wr_data <= 16'hBEEF;
      @(posedge ref_clk);
      scan_tick <= 0;
      mnt_wr_en <= 0;
      #1;
      for (i = 0; i < 40 && done_ff !== 1'b1; i++) @(posedge ref_clk) #1;
      // Three words end two cycles after the first write edge
      chk(i, 2);
      chk(carry_ff, 1'b0);
      mem(1'b0, 2'h1, 10'h008, 16'h0F0F);
      mem(1'b0, 2'h1, 10'h009, 16'h0000);
   endtask
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge ref_clk);
      nrst <= 1;
      t_ones();
      t_carry();
      t_indirect();
      t_block();
      t_refuse();
      end_sim();
   end
   // Cut a hang short
   initial begin
      #100000;
      fail_count++;
      end_sim();
   end
endmodule
